/* File: logic/gpio_port_defines.svh */
/*
 Register offsets, field positions and reset values of the port A block.
 Assumes inclusion by bare name from the port module and the bench.
*/
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

// Byte offsets on the AXI4-Lite bus
`define PA_OFF_DATA 8'h00
`define PA_OFF_DIR 8'h04
`define PA_OFF_PULL 8'h08
`define PA_OFF_SLEW 8'h0C
`define PA_OFF_DRIVE 8'h10
`define PA_OFF_PWR 8'h14

// Implemented pins: positions 5 and 0
`define PA_IMPL_MASK 8'h21

// Reset values
`define PA_DATA_RST 8'h00
`define PA_DIR_RST 8'h00
`define PA_PULL_RST 8'h00
`define PA_SLEW_RST 8'h21
`define PA_DRIVE_RST 8'h00

// Power status register fields
`define PA_FLAG_BIT 3
`define PA_ACK_BIT 2

`endif

/* File: logic/gpio_port_pkg.sv */
/*
 Types shared by the port A block and its bus front end.
 Assumes the defines header is available on the include path.
*/
package gpio_port_pkg;

    typedef logic [7:0] port_byte_t;

    typedef enum logic [1:0] {
        RESP_OKAY = 2'h0,
        RESP_SLVERR = 2'h2
    } axi_resp_e;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_DATA,
        SEL_DIR,
        SEL_PULL,
        SEL_SLEW,
        SEL_DRIVE,
        SEL_PWR
    } reg_sel_e;

endpackage : gpio_port_pkg

/* File: logic/reg_port_if.sv */
/*
 Simple register access carrier between the bus front end and the port.
 Assumes one clock; the register side answers combinationally.
*/
`timescale 1ns/1ns
interface reg_port_if #(parameter int ADDR_W = 8);
    logic wr_en;
    logic wr_be0;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_ok;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_ok;

    modport slv (
        output wr_en, wr_be0, wr_addr, wr_data, rd_addr,
        input wr_ok, rd_data, rd_ok
    );
    modport regs (
        input wr_en, wr_be0, wr_addr, wr_data, rd_addr,
        output wr_ok, rd_data, rd_ok
    );
endinterface : reg_port_if

/* File: logic/axil_reg_slave.sv */
/*
 AXI4-Lite slave front end: one write and one read at a time.
 Assumes the register side decodes addresses without delay.
*/
`timescale 1ns/1ns
module axil_reg_slave
    import gpio_port_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read channels
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register side
    reg_port_if.slv rb
);

    logic aw_have_q, w_have_q, wbe_q, rd_pend_q;
    logic [ADDR_W-1:0] awaddr_q, rd_addr_q;
    logic [7:0] wdata_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    axi_resp_e bresp_q, rresp_q;
    logic [31:0] rdata_q;

    ////////////////////////////////////////////////////////////////////////
    wire aw_fire = awvalid & awready_q;
    wire w_fire = wvalid & wready_q;
    wire do_write = aw_have_q & w_have_q & ~bvalid_q;
    wire aw_have_d = ~do_write & (aw_have_q | aw_fire);
    wire w_have_d = ~do_write & (w_have_q | w_fire);
    wire bvalid_d = do_write | (bvalid_q & ~bready);
    wire ar_fire = arvalid & arready_q;
    wire rvalid_d = rd_pend_q | (rvalid_q & ~rready);

    assign rb.wr_en = do_write;
    assign rb.wr_be0 = wbe_q;
    assign rb.wr_addr = awaddr_q;
    assign rb.wr_data = wdata_q;
    assign rb.rd_addr = rd_addr_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            bvalid_q <= bvalid_d;
            // Address and data are taken in either order, then held
            awready_q <= ~aw_have_d & ~bvalid_d;
            wready_q <= ~w_have_d & ~bvalid_d;
            if (do_write) begin
                bresp_q <= rb.wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            wbe_q <= 1'b0;
        end else begin
            if (aw_fire) begin
                awaddr_q <= awaddr;
            end
            if (w_fire) begin
                wdata_q <= wdata[7:0];
                wbe_q <= wstrb[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_pend_q <= 1'b0;
            rd_addr_q <= '0;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else begin
            rd_pend_q <= ar_fire;
            arready_q <= ~ar_fire & ~rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_fire) begin
                rd_addr_q <= araddr;
            end
            if (rd_pend_q) begin
                rdata_q <= {24'h00_0000, rb.rd_data};
                rresp_q <= rb.rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

endmodule : axil_reg_slave

/* File: logic/parallel_port_a_gpio.sv */
/*
 Port A general-purpose I/O: data latch, direction, pullup, slew, drive,
 and pin hold through partial power-down with software recovery.
 Assumes an AXI4-Lite master on aclk and pins sampled asynchronously.
*/
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "gpio_port_defines.svh"
module parallel_port_a_gpio
    import gpio_port_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter port_byte_t IMPL_MASK = `PA_IMPL_MASK
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Power management
    input wire logic partial_powerdown_stop,
    output logic powerdown_recovery_flag,
    // Pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output logic [7:0] pullup_en,
    output logic [7:0] slew_en,
    output logic [7:0] drive_high
);

    reg_port_if #(.ADDR_W(ADDR_W)) rbus ();

    axil_reg_slave #(.ADDR_W(ADDR_W)) u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .rb(rbus.slv)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode, shared by reads and writes
    function automatic reg_sel_e sel_of(input logic [ADDR_W-1:0] a);
        reg_sel_e s;
        s = SEL_NONE;
        if (a == ADDR_W'(`PA_OFF_DATA)) s = SEL_DATA;
        if (a == ADDR_W'(`PA_OFF_DIR)) s = SEL_DIR;
        if (a == ADDR_W'(`PA_OFF_PULL)) s = SEL_PULL;
        if (a == ADDR_W'(`PA_OFF_SLEW)) s = SEL_SLEW;
        if (a == ADDR_W'(`PA_OFF_DRIVE)) s = SEL_DRIVE;
        if (a == ADDR_W'(`PA_OFF_PWR)) s = SEL_PWR;
        return s;
    endfunction : sel_of

    port_byte_t data_q, dir_q, pull_q, slew_q, drive_q;
    port_byte_t pin_s1_q, pin_s2_q;
    logic flag_q, hold_q, pp_q;
    port_byte_t pin_out_q, oe_n_q, pullup_q, slew_out_q, drive_out_q;

    wire reg_sel_e wr_sel = sel_of(rbus.wr_addr);
    wire reg_sel_e rd_sel = sel_of(rbus.rd_addr);
    wire wr_go = rbus.wr_en & rbus.wr_be0 & rbus.wr_ok;
    wire port_byte_t wd = rbus.wr_data & IMPL_MASK;
    wire ack = wr_go & (wr_sel == SEL_PWR) & rbus.wr_data[`PA_ACK_BIT];
    wire stop_entry = partial_powerdown_stop & ~pp_q;
    wire wake = ~partial_powerdown_stop & pp_q;
    // Pads follow the registers except while frozen by partial power-down
    wire pad_upd = ~hold_q & ~stop_entry;

    assign rbus.wr_ok = (wr_sel != SEL_NONE);
    assign rbus.rd_ok = (rd_sel != SEL_NONE);

    ////////////////////////////////////////////////////////////////////////
    // Read path
    wire port_byte_t port_val = ((dir_q & data_q) | (~dir_q & pin_s2_q)) & IMPL_MASK;
    wire port_byte_t pwr_val = port_byte_t'({flag_q, 3'b000});

    assign rbus.rd_data = (rd_sel == SEL_DATA) ? port_val :
                          (rd_sel == SEL_DIR) ? dir_q :
                          (rd_sel == SEL_PULL) ? pull_q :
                          (rd_sel == SEL_SLEW) ? slew_q :
                          (rd_sel == SEL_DRIVE) ? drive_q :
                          (rd_sel == SEL_PWR) ? pwr_val : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser; only the second stage feeds logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
        end else begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Registers change only by bus writes, so a powered stop loses nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= `PA_DATA_RST;
            dir_q <= `PA_DIR_RST;
            pull_q <= `PA_PULL_RST;
            slew_q <= `PA_SLEW_RST;
            drive_q <= `PA_DRIVE_RST;
        end else if (wr_go) begin
            if (wr_sel == SEL_DATA) data_q <= wd;
            if (wr_sel == SEL_DIR) dir_q <= wd;
            if (wr_sel == SEL_PULL) pull_q <= wd;
            if (wr_sel == SEL_SLEW) slew_q <= wd;
            if (wr_sel == SEL_DRIVE) drive_q <= wd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Partial power-down: hold from entry until acknowledge; flag on wake.
    // Wake beats a same-cycle acknowledge so no recovery is missed.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pp_q <= 1'b0;
            hold_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            pp_q <= partial_powerdown_stop;
            if (stop_entry) hold_q <= 1'b1;
            else if (ack) hold_q <= 1'b0;
            if (wake) flag_q <= 1'b1;
            else if (ack) flag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pad controls, registered per pin
    for (genvar i = 0; i < 8; i++) begin : g_pad
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pin_out_q[i] <= 1'b0;
                oe_n_q[i] <= 1'b1;
                pullup_q[i] <= 1'b0;
                slew_out_q[i] <= 1'b0;
                drive_out_q[i] <= 1'b0;
            end else if (pad_upd && IMPL_MASK[i]) begin
                pin_out_q[i] <= data_q[i] & dir_q[i];
                oe_n_q[i] <= ~dir_q[i];
                pullup_q[i] <= pull_q[i] & ~dir_q[i];
                slew_out_q[i] <= slew_q[i] & dir_q[i];
                drive_out_q[i] <= drive_q[i] & dir_q[i];
            end
        end
    end

    assign pin_out = pin_out_q;
    assign pin_oe_n = oe_n_q;
    assign pullup_en = pullup_q;
    assign slew_en = slew_out_q;
    assign drive_high = drive_out_q;
    assign powerdown_recovery_flag = flag_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic rd_data_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) rd_data_q <= 1'b0;
        else rd_data_q <= (rd_sel == SEL_DATA);
    end

    sequence s_stop_entry;
        $rose(partial_powerdown_stop);
    endsequence
    sequence s_ack_write;
        wr_go && wr_sel == SEL_PWR && rbus.wr_data[`PA_ACK_BIT] && !wake && !stop_entry;
    endsequence

    property p_hold_pins;
        s_stop_entry ##0 !ack |=> ($stable(pin_out) && $stable(pin_oe_n)) [*2];
    endproperty
    a_hold_pins: assert property (p_hold_pins) else $error("pins moved in stop");

    property p_regs_kept;
        !rbus.wr_en |=> $stable(data_q) && $stable(dir_q) && $stable(pull_q);
    endproperty
    a_regs_kept: assert property (p_regs_kept) else $error("port state lost");

    property p_read_input;
        rd_data_q && $rose(rvalid) && !$past(dir_q[0]) |-> rdata[0] == $past(pin_s2_q[0]);
    endproperty
    a_read_input: assert property (p_read_input) else $error("input read wrong");

    property p_read_output;
        rd_data_q && $rose(rvalid) && $past(dir_q[5]) |-> rdata[5] == $past(data_q[5]);
    endproperty
    a_read_output: assert property (p_read_output) else $error("output read wrong");

    property p_data_write;
        wr_go && wr_sel == SEL_DATA |=> data_q == $past(rbus.wr_data & IMPL_MASK);
    endproperty
    a_data_write: assert property (p_data_write) else $error("latch not written");

    property p_reset;
        disable iff (1'b0) !aresetn |=> data_q == 8'h00 && pin_oe_n == 8'hFF && pullup_en == 8'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");

    property p_dir_drive;
        pad_upd && dir_q[0] |=> !pin_oe_n[0] && pin_out[0] == $past(data_q[0]);
    endproperty
    a_dir_drive: assert property (p_dir_drive) else $error("driver not on");

    property p_pull_off;
        (~pin_oe_n & pullup_en) == 8'h00;
    endproperty
    a_pull_off: assert property (p_pull_off) else $error("pullup on output");

    property p_slew_input;
        slew_en[0] |-> !pin_oe_n[0];
    endproperty
    a_slew_input: assert property (p_slew_input) else $error("slew on input");

    property p_drive_high;
        pad_upd && dir_q[5] && drive_q[5] |=> drive_high[5];
    endproperty
    a_drive_high: assert property (p_drive_high) else $error("drive not high");

    property p_flag_set;
        $fell(partial_powerdown_stop) |-> ##[0:1] powerdown_recovery_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_flag_clear;
        s_ack_write |=> !powerdown_recovery_flag && !hold_q;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("ack did not clear");

    property p_unimpl;
        ((data_q | dir_q | pull_q | slew_q | drive_q) & ~IMPL_MASK) == 8'h00;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

endmodule : parallel_port_a_gpio

/* File: sim/board_pins_model.sv */
/*
 Board circuitry at the port pins: an external source per pin, or nothing.
 Assumes the device's pad outputs are registered on aclk.
*/
`timescale 1ns/1ns
module board_pins_model (
    // Clock
    input wire logic aclk,
    // Device pads
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pullup_en,
    // External sources
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    // Level seen by the device
    output logic [7:0] pin_in
);
    logic [7:0] float_q;

    // Undriven lines wander, so a stale level never reads as valid
    always @(posedge aclk) begin
        float_q <= ~float_q;
    end

    initial float_q = 8'h55;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pullup_en[i]) pin_in[i] = 1'b1;
            else pin_in[i] = float_q[i];
        end
    end
endmodule : board_pins_model

/* File: sim/parallel_port_a_gpio_bench.sv */
/*
 Self-checking bench of port A: register bus, pads and recovery sequence.
 Assumes the board model above and the design's defines header.
*/
`timescale 1ns/1ns
`include "gpio_port_defines.svh"
module parallel_port_a_gpio_bench;
    import gpio_port_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
    logic awready, wready, arready, stop, flag;
    logic [7:0] awaddr, araddr, pin_in, pin_out, pin_oe_n, pullup_en, slew_en, drive_high;
    logic [7:0] ext_val, ext_en;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [3:0] strb = 4'hf;
    logic [1:0] bresp, rresp;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;

    parallel_port_a_gpio i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .partial_powerdown_stop(stop), .powerdown_recovery_flag(flag),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
        .slew_en(slew_en), .drive_high(drive_high));

    board_pins_model i_board (.aclk(aclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s: saw %h, expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
    endtask : settle

    // Address and data offered together, released each on its own ready
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 1'b0;
        check(bresp, exp_resp, "write response");
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        check(rresp, exp_resp, "read response");
        check(rdata, exp, "read data");
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        ext_val <= 8'hff;
        ext_en <= 8'hff;
        settle(3);
        check(pin_oe_n, 8'hff, "pads undriven");
        check({pin_out, pullup_en, slew_en, drive_high}, 32'h0000_0000, "pads off");
        rd(`PA_OFF_PWR, 32'h0000_0000, RESP_OKAY);
        rd(`PA_OFF_DATA, 32'h0000_0021, RESP_OKAY);
        rd(`PA_OFF_DIR, 32'h0000_0000, RESP_OKAY);
        rd(`PA_OFF_PULL, 32'h0000_0000, RESP_OKAY);
        rd(`PA_OFF_SLEW, 32'h0000_0021, RESP_OKAY);
        rd(`PA_OFF_DRIVE, 32'h0000_0000, RESP_OKAY);
    endtask : t_reset

    task automatic t_dir_data();
        ext_val <= 8'h01;
        wr(`PA_OFF_DATA, 32'h0000_0020, RESP_OKAY);
        settle(3);
        check({pin_oe_n, pin_out}, 16'hff00, "latch not driven on input");
        rd(`PA_OFF_DATA, 32'h0000_0001, RESP_OKAY);
        wr(`PA_OFF_DIR, 32'h0000_0020, RESP_OKAY);
        settle(3);
        check({pin_oe_n, pin_out}, 16'hdf20, "output drives latch");
        rd(`PA_OFF_DATA, 32'h0000_0021, RESP_OKAY);
        ext_val <= 8'h00;
        settle(3);
        rd(`PA_OFF_DATA, 32'h0000_0020, RESP_OKAY);
        wr(`PA_OFF_DIR, 32'h0000_00ff, RESP_OKAY);
        rd(`PA_OFF_DIR, 32'h0000_0021, RESP_OKAY);
        wr(`PA_OFF_DATA, 32'h0000_00ff, RESP_OKAY);
        settle(3);
        check({pin_oe_n, pin_out}, 16'hde21, "both outputs high");
        rd(`PA_OFF_DATA, 32'h0000_0021, RESP_OKAY);
    endtask : t_dir_data

    task automatic t_pin_ctrl();
        wr(`PA_OFF_DATA, 32'h0000_0000, RESP_OKAY);
        wr(`PA_OFF_DIR, 32'h0000_0001, RESP_OKAY);
        ext_en <= 8'h00;
        wr(`PA_OFF_PULL, 32'h0000_00ff, RESP_OKAY);
        wr(`PA_OFF_DRIVE, 32'h0000_00ff, RESP_OKAY);
        settle(3);
        check(pullup_en, 8'h20, "pullup only on input");
        check(slew_en, 8'h01, "slew only on output");
        check(drive_high, 8'h01, "high drive on output");
        rd(`PA_OFF_PULL, 32'h0000_0021, RESP_OKAY);
        rd(`PA_OFF_DATA, 32'h0000_0020, RESP_OKAY);
        wr(`PA_OFF_DRIVE, 32'h0000_0000, RESP_OKAY);
        wr(`PA_OFF_SLEW, 32'h0000_0000, RESP_OKAY);
        settle(3);
        check({slew_en, drive_high}, 16'h0000, "low drive, no slew");
        rd(`PA_OFF_DRIVE, 32'h0000_0000, RESP_OKAY);
    endtask : t_pin_ctrl

    task automatic t_unmapped();
        wr(8'h18, 32'h0000_00ff, RESP_SLVERR);
        rd(8'h18, 32'h0000_0000, RESP_SLVERR);
        // Low byte strobe off: answered, register untouched
        strb = 4'h0;
        wr(`PA_OFF_DIR, 32'h0000_00ff, RESP_OKAY);
        strb = 4'hf;
        rd(`PA_OFF_DIR, 32'h0000_0001, RESP_OKAY);
    endtask : t_unmapped

    task automatic t_powerdown();
        wr(`PA_OFF_DIR, 32'h0000_0021, RESP_OKAY);
        wr(`PA_OFF_DATA, 32'h0000_0001, RESP_OKAY);
        // Saved copy: data 01, direction 21
        rd(`PA_OFF_DATA, 32'h0000_0001, RESP_OKAY);
        @(posedge aclk);
        stop <= 1'b1;
        settle(2);
        wr(`PA_OFF_DATA, 32'h0000_0020, RESP_OKAY);
        wr(`PA_OFF_DIR, 32'h0000_0000, RESP_OKAY);
        settle(3);
        check({pin_oe_n, pin_out}, 16'hde01, "pads frozen");
        stop <= 1'b0;
        settle(2);
        check(flag, 1'b1, "flag after wake");
        rd(`PA_OFF_PWR, 32'h0000_0008, RESP_OKAY);
        wr(`PA_OFF_PWR, 32'h0000_0008, RESP_OKAY);
        settle(2);
        check(flag, 1'b1, "flag is read only");
        wr(`PA_OFF_DIR, 32'h0000_0021, RESP_OKAY);
        wr(`PA_OFF_DATA, 32'h0000_0001, RESP_OKAY);
        wr(`PA_OFF_PWR, 32'h0000_0004, RESP_OKAY);
        settle(2);
        check(flag, 1'b0, "flag cleared");
        rd(`PA_OFF_PWR, 32'h0000_0000, RESP_OKAY);
        wr(`PA_OFF_DATA, 32'h0000_0020, RESP_OKAY);
        settle(3);
        check({pin_oe_n, pin_out}, 16'hde20, "port live after ack");
    endtask : t_powerdown

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) begin
        cycles++;
        if (cycles >= 5000) begin
            n_fail++;
            close_out();
        end
    end

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, stop} = 6'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
        ext_val = 8'h00;
        ext_en = 8'h00;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_dir_data();
        t_pin_ctrl();
        t_unmapped();
        t_powerdown();
        close_out();
    end
endmodule : parallel_port_a_gpio_bench
